// [buck_gate_drive_decode.sv]
`timescale 1ns/1ns
//
// Contract
// - Synchronous mode, pulse high: high-side switch on, low-side off.
// - Synchronous mode, pulse low: high-side off, low-side on.
// - Synchronous mode inserts dead time before the complementary switch.
// - Non-synchronous mode: pulse drives only high side; low side off.
// - Pulse in mid band past the hold-off time: both switches off.
// - Three-state detection overrides the rectifier-enable input.
module buck_gate_drive_decode (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic pulseAboveHigh,
  input  wire logic pulseBelowLow,
  input  wire logic sync_rectifier_enable,
  output logic      high_side_switch,
  output logic      low_side_switch,
  output logic      tristateActive
);

  // --------------------------------------------------------------------------
  // Input conditioning
  // --------------------------------------------------------------------------
  bgd_pkg::bgd_class_type pulseClass;
  logic                   enableSyncFirst_reg;
  logic                   enableSyncFirst_next;
  logic                   enableSync_reg;
  logic                   enableSync_next;

  bgd_pulse_classifier u_classifier (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .pulseAboveHigh (pulseAboveHigh),
    .pulseBelowLow  (pulseBelowLow),
    .pulseClass     (pulseClass)
  );

  // The enable is a pin level as well and gets the same two flops; the
  // extra latency only delays a change of mode
  always_comb begin
    enableSyncFirst_next = sync_rectifier_enable;
    enableSync_next      = enableSyncFirst_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      enableSyncFirst_reg <= 1'h0;
      enableSync_reg      <= 1'h0;
    end else begin
      enableSyncFirst_reg <= enableSyncFirst_next;
      enableSync_reg      <= enableSync_next;
    end
  end

  // --------------------------------------------------------------------------
  // Counter helper
  // --------------------------------------------------------------------------
  function automatic logic [bgd_pkg::CNT_W-1:0] count_step(
    input logic [bgd_pkg::CNT_W-1:0] count
  );
    return count + 1'b1;
  endfunction

  // --------------------------------------------------------------------------
  // Three-state hold-off
  // --------------------------------------------------------------------------
  logic [bgd_pkg::CNT_W-1:0] holdCount_reg;
  logic [bgd_pkg::CNT_W-1:0] holdCount_next;
  logic                      holdExpired;

  localparam logic [bgd_pkg::CNT_W-1:0] HOLD_LIMIT =
    bgd_pkg::CNT_W'(bgd_pkg::HOLDOFF_CYCLES);

  // Any clean low or high level restarts the dwell, so glitches through the
  // band while switching never accumulate
  always_comb begin
    holdCount_next = holdCount_reg;
    if (pulseClass != bgd_pkg::PULSE_MID)
      holdCount_next = '0;
    else if (holdCount_reg < HOLD_LIMIT)
      holdCount_next = count_step(holdCount_reg);
  end

  // Saturates at the limit so a long float never wraps back to zero; the
  // dwell is only resolved to one clock period
  assign holdExpired = (holdCount_reg >= HOLD_LIMIT);

  always_ff @(posedge core_clk) begin
    if (!reset_n)
      holdCount_reg <= '0;
    else
      holdCount_reg <= holdCount_next;
  end

  // --------------------------------------------------------------------------
  // Drive state machine
  // --------------------------------------------------------------------------
  localparam logic [bgd_pkg::CNT_W-1:0] DEAD_LIMIT =
    bgd_pkg::CNT_W'(bgd_pkg::DEAD_CYCLES);

  bgd_pkg::bgd_state_type    state_reg;
  bgd_pkg::bgd_state_type    state_next;
  logic [bgd_pkg::CNT_W-1:0] deadCount_reg;
  logic [bgd_pkg::CNT_W-1:0] deadCount_next;
  logic                      highSide_next;
  logic                      lowSide_next;
  logic                      highSide_reg;
  logic                      lowSide_reg;
  logic                      tristate_reg;
  logic                      tristate_next;
  logic                      pulseHigh;
  logic                      pulseLow;

  assign pulseHigh = (pulseClass == bgd_pkg::PULSE_HIGH);
  assign pulseLow  = (pulseClass == bgd_pkg::PULSE_LOW);

  // Picks the drive once both switches are known to be off. A mid-band
  // level gives the fallback, so an edge crossing the band never turns a
  // switch on by itself
  function automatic bgd_pkg::bgd_state_type settle_state(
    input logic                   isHigh,
    input logic                   isLow,
    input logic                   syncMode,
    input bgd_pkg::bgd_state_type fallback
  );
    bgd_pkg::bgd_state_type result;
    result = fallback;
    if (isHigh)
      result = bgd_pkg::ST_HIGH_ON;
    else if (isLow && syncMode)
      result = bgd_pkg::ST_LOW_ON;
    else if (isLow)
      result = bgd_pkg::ST_OFF;
    return result;
  endfunction

  // A mid-band level before hold-off expiry keeps the previous drive: the
  // input passes through the band on every edge and must not chop pulses
  always_comb begin
    state_next     = state_reg;
    deadCount_next = deadCount_reg;
    if (holdExpired) begin
      state_next     = bgd_pkg::ST_TRISTATE;
      deadCount_next = '0;
    end else begin
      unique case (state_reg)
        bgd_pkg::ST_OFF, bgd_pkg::ST_TRISTATE: begin
          // Both switches off already, so dead time has elapsed except right after ST_LOW_ON exits on enable low
          state_next = settle_state(pulseHigh, pulseLow, enableSync_reg,
                                    state_reg);
        end
        // Also taken in non-synchronous mode, so the next pulse still
        // waits out the dead time
        bgd_pkg::ST_HIGH_ON: begin
          if (pulseLow) begin
            state_next     = bgd_pkg::ST_DEAD;
            deadCount_next = '0;
          end
        end
        // Enable low drops the low side at once: turning a switch off
        // needs no dead time
        bgd_pkg::ST_LOW_ON: begin
          if (!enableSync_reg)
            state_next = bgd_pkg::ST_OFF;
          else if (pulseHigh) begin
            state_next     = bgd_pkg::ST_DEAD;
            deadCount_next = '0;
          end
        end
        bgd_pkg::ST_DEAD: begin
          deadCount_next = count_step(deadCount_reg);
          if (count_step(deadCount_reg) >= DEAD_LIMIT) begin
            deadCount_next = '0;
            state_next     = settle_state(pulseHigh, pulseLow,
                                          enableSync_reg, bgd_pkg::ST_OFF);
          end
        end
        // A code outside the one-hot set is an upset: park both switches
        // off and let the next clean level decide
        default: begin
          state_next     = bgd_pkg::ST_OFF;
          deadCount_next = '0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  // Decoding the next state keeps every gate one flop from the pins with
  // no extra cycle of latency
  always_comb begin
    highSide_next = (state_next == bgd_pkg::ST_HIGH_ON);
    lowSide_next  = (state_next == bgd_pkg::ST_LOW_ON);
    tristate_next = (state_next == bgd_pkg::ST_TRISTATE);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg     <= bgd_pkg::ST_OFF;
      deadCount_reg <= '0;
      highSide_reg  <= 1'h0;
      lowSide_reg   <= 1'h0;
      tristate_reg  <= 1'h0;
    end else begin
      state_reg     <= state_next;
      deadCount_reg <= deadCount_next;
      highSide_reg  <= highSide_next;
      lowSide_reg   <= lowSide_next;
      tristate_reg  <= tristate_next;
    end
  end

  assign high_side_switch = highSide_reg;
  assign low_side_switch  = lowSide_reg;
  assign tristateActive   = tristate_reg;

endmodule

// [bgd_pkg.sv]
package bgd_pkg;

  // --------------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 40;
  // Minimum dead time between one switch turning off and the other turning on
  localparam int DEAD_TIME_NS      = 80;
  localparam int DEAD_CYCLES       =
    (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Mid-band dwell before three-state entry; arbitrary plain default
  localparam int HOLDOFF_TIME_NS   = 400;
  localparam int HOLDOFF_CYCLES    =
    (HOLDOFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 8;

  // --------------------------------------------------------------------------
  // Pulse input classes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PULSE_LOW  = 2'h0,
    PULSE_HIGH = 2'h1,
    PULSE_MID  = 2'h2
  } bgd_class_type;

  // --------------------------------------------------------------------------
  // Drive states
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF      = 5'h01,
    ST_HIGH_ON  = 5'h02,
    ST_LOW_ON   = 5'h04,
    ST_DEAD     = 5'h08,
    ST_TRISTATE = 5'h10
  } bgd_state_type;

endpackage

// [bgd_pulse_classifier.sv]
`timescale 1ns/1ns
// Synchronises the comparator outputs and sorts the pulse input into classes
module bgd_pulse_classifier (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   pulseAboveHigh,
  input  wire logic                   pulseBelowLow,
  output bgd_pkg::bgd_class_type      pulseClass
);

  logic [1:0] syncFirst_reg;
  logic [1:0] syncFirst_next;
  logic [1:0] syncSecond_reg;
  logic [1:0] syncSecond_next;
  bgd_pkg::bgd_class_type classValue;

  always_comb begin
    syncFirst_next  = {pulseAboveHigh, pulseBelowLow};
    syncSecond_next = syncFirst_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // Reset to the low class, so nothing counts toward the hold-off
      syncFirst_reg  <= 2'h1;
      syncSecond_reg <= 2'h1;
    end else begin
      syncFirst_reg  <= syncFirst_next;
      syncSecond_reg <= syncSecond_next;
    end
  end

  // Both comparators set cannot be a real level; treat it as low (safe side)
  always_comb begin
    if (syncSecond_reg[0])
      classValue = bgd_pkg::PULSE_LOW;
    else if (syncSecond_reg[1])
      classValue = bgd_pkg::PULSE_HIGH;
    else
      classValue = bgd_pkg::PULSE_MID;
  end

  assign pulseClass = classValue;

endmodule

// [bgd_props.sv]
`timescale 1ns/1ns
module bgd_gate_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic pulseAboveHigh,
  input wire logic pulseBelowLow,
  input wire logic sync_rectifier_enable,
  input wire logic high_side_switch,
  input wire logic low_side_switch,
  input wire logic tristateActive
);
  logic [7:0] midCnt_reg;
  logic [7:0] midCnt_next;
  logic       midIn;
  logic       highIn;
  assign midIn  = !pulseAboveHigh && !pulseBelowLow;
  assign highIn = pulseAboveHigh && !pulseBelowLow;
  // -------------------------------------------------------------------------
  // Mid-band dwell, saturating so a long float never wraps
  // -------------------------------------------------------------------------
  always_comb begin
    midCnt_next = midCnt_reg;
    if (!midIn)
      midCnt_next = 8'h00;
    else if (midCnt_reg != 8'hff)
      midCnt_next = midCnt_reg + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    midCnt_reg <= reset_n ? midCnt_next : 8'h00;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // -------------------------------------------------------------------------
  // Assertions; windows allow sync plus dead time
  // -------------------------------------------------------------------------
  no_overlap_a: assert property (
      !(high_side_switch && low_side_switch))
    else $error("both switches on");
  dead_gap_a: assert property (
      $fell(low_side_switch) |-> !high_side_switch[*2])
    else $error("high side on inside dead time");
  dead_gap_low_a: assert property (
      $fell(high_side_switch) |-> !low_side_switch[*2])
    else $error("low side on inside dead time");
  sync_high_a: assert property (
      highIn[*7] |-> high_side_switch && !low_side_switch)
    else $error("high pulse not decoded");
  sync_low_a: assert property (
      (pulseBelowLow && sync_rectifier_enable)[*7]
      |-> low_side_switch && !high_side_switch)
    else $error("low pulse not decoded in sync mode");
  async_low_a: assert property (
      (!sync_rectifier_enable)[*4] |-> !low_side_switch)
    else $error("low side on with enable low");
  float_off_a: assert property (
      midCnt_reg >= 8'(bgd_pkg::HOLDOFF_CYCLES + 4)
      |-> tristateActive && !high_side_switch && !low_side_switch)
    else $error("no three-state after hold-off");
  holdoff_min_a: assert property (
      $rose(tristateActive) |-> midCnt_reg >= bgd_pkg::HOLDOFF_CYCLES)
    else $error("three-state entered before hold-off");
  float_exit_a: assert property (
      (!midIn)[*5] |-> !tristateActive)
    else $error("three-state kept on clean input");
  cover property ($rose(tristateActive));
  cover property ($rose(high_side_switch) && sync_rectifier_enable);
  cover property ($rose(low_side_switch));
endmodule
bind buck_gate_drive_decode bgd_gate_props i_bgd_gate_props (
  .core_clk(core_clk), .reset_n(reset_n), .pulseAboveHigh(pulseAboveHigh),
  .pulseBelowLow(pulseBelowLow),
  .sync_rectifier_enable(sync_rectifier_enable),
  .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
  .tristateActive(tristateActive));

// [bgd_controller_model.sv]
`timescale 1ns/1ns
// Controller output seen through the pin comparators; a released pin
// settles in the mid band, so both comparators read low
module bgd_controller_model (
  input  wire logic                  core_clk,
  input  wire bgd_pkg::bgd_class_type level,
  output logic                       pulseAboveHigh,
  output logic                       pulseBelowLow
);
  // Caller holds each level 8 cycles or more, below 2 MHz
  always_ff @(posedge core_clk) begin
    pulseAboveHigh <= (level == bgd_pkg::PULSE_HIGH);
    pulseBelowLow  <= (level == bgd_pkg::PULSE_LOW);
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic core_clk, reset_n, sync_rectifier_enable, overlapSeen;
  logic hs, ls, ts, pulseAboveHigh, pulseBelowLow;
  bgd_pkg::bgd_class_type level;
  int errors, total_checks;
  bgd_controller_model i_bgd_controller_model (.core_clk(core_clk),
    .level(level), .pulseAboveHigh(pulseAboveHigh),
    .pulseBelowLow(pulseBelowLow));
  buck_gate_drive_decode i_buck_gate_drive_decode (.core_clk(core_clk),
    .reset_n(reset_n), .pulseAboveHigh(pulseAboveHigh),
    .pulseBelowLow(pulseBelowLow),
    .sync_rectifier_enable(sync_rectifier_enable),
    .high_side_switch(hs), .low_side_switch(ls), .tristateActive(ts));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (reset_n && hs && ls)
      overlapSeen <= 1'b1;
  end
  task automatic drive(input bgd_pkg::bgd_class_type lv, input logic en,
                       input int n);
    @(posedge core_clk);
    level <= lv;
    sync_rectifier_enable <= en;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [2:0] exp,
                     input logic [2:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic sync_mode;
    drive(bgd_pkg::PULSE_HIGH, 1'b1, 10);
    cmp("sync high", 3'b100, {hs, ls, ts});
    drive(bgd_pkg::PULSE_LOW, 1'b1, 10);
    cmp("sync low", 3'b010, {hs, ls, ts});
    drive(bgd_pkg::PULSE_HIGH, 1'b1, 10);
    cmp("overlap", 3'b000, {2'b00, overlapSeen});
  endtask
  task automatic gap_after(input bgd_pkg::bgd_class_type lv,
                           output int gap);
    gap = 0;
    @(posedge core_clk);
    level <= lv;
    repeat (10) begin
      @(posedge core_clk);
      #1;
      if (!hs && !ls)
        gap++;
    end
  endtask
  task automatic dead_gap;
    int   gap;
    logic gapOk;
    drive(bgd_pkg::PULSE_LOW, 1'b1, 10);
    gap_after(bgd_pkg::PULSE_HIGH, gap);
    gapOk = (gap == bgd_pkg::DEAD_CYCLES);
    cmp("dead gap rise", 3'b101, {hs, ls, gapOk});
    gap_after(bgd_pkg::PULSE_LOW, gap);
    gapOk = (gap == bgd_pkg::DEAD_CYCLES);
    cmp("dead gap fall", 3'b011, {hs, ls, gapOk});
  endtask
  task automatic async_mode;
    drive(bgd_pkg::PULSE_LOW, 1'b1, 10);
    drive(bgd_pkg::PULSE_LOW, 1'b0, 10);
    cmp("async low", 3'b000, {hs, ls, ts});
    drive(bgd_pkg::PULSE_HIGH, 1'b0, 10);
    cmp("async high", 3'b100, {hs, ls, ts});
    drive(bgd_pkg::PULSE_LOW, 1'b0, 10);
    cmp("async drop", 3'b000, {hs, ls, ts});
  endtask
  task automatic float_entry;
    for (int e = 0; e < 2; e++) begin
      drive(bgd_pkg::PULSE_HIGH, e[0], 10);
      drive(bgd_pkg::PULSE_MID, e[0], 20);
      cmp("float", 3'b001, {hs, ls, ts});
    end
  endtask
  task automatic short_float;
    drive(bgd_pkg::PULSE_LOW, 1'b1, 10);
    drive(bgd_pkg::PULSE_MID, 1'b1, bgd_pkg::HOLDOFF_CYCLES - 3);
    cmp("short float", 3'b010, {hs, ls, ts});
    drive(bgd_pkg::PULSE_LOW, 1'b1, 7);
    drive(bgd_pkg::PULSE_MID, 1'b1, bgd_pkg::HOLDOFF_CYCLES - 3);
    cmp("float restart", 3'b010, {hs, ls, ts});
  endtask
  task automatic leave_float;
    drive(bgd_pkg::PULSE_MID, 1'b1, 20);
    drive(bgd_pkg::PULSE_LOW, 1'b1, 10);
    cmp("exit low", 3'b010, {hs, ls, ts});
    drive(bgd_pkg::PULSE_HIGH, 1'b1, 10);
    cmp("exit high", 3'b100, {hs, ls, ts});
  endtask
  task automatic print_verdict;
    $display("TB: checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    sync_rectifier_enable = 1'b1;
    level = bgd_pkg::PULSE_LOW;
    overlapSeen = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    cmp("reset", 3'b000, {hs, ls, ts});
    sync_mode();
    dead_gap();
    async_mode();
    float_entry();
    short_float();
    leave_float();
    print_verdict();
  end
  // Run needs about 260 cycles; allow ample margin
  initial begin
    #30000;
    errors++;
    print_verdict();
  end
endmodule
